/* File: hw/lfa_alu_unit.sv */
// combinational arithmetic, logic and bit operations with flag results
`timescale 1ns/1ps
module lfa_alu_unit (
	// operation and operands
	input  wire lfa_pkg::op_t op,
	input  wire logic [7:0]   acc,
	input  wire logic [7:0]   literal,
	input  wire logic [7:0]   fdata,
	input  wire logic [2:0]   bsel,
	// results
	output logic [7:0]        result,
	output logic              carry,
	output logic              half_carry,
	output logic              zero,
	output logic              bit_val
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] operand;
	logic [7:0] mask;

	always_comb begin
		mask    = 8'h01 << bsel;
		operand = (op == lfa_pkg::OP_ADD_IMM || op == lfa_pkg::OP_AND_IMM)
			? literal : fdata;
		sum     = {1'b0, acc} + {1'b0, operand};
		low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
		bit_val = |(fdata & mask);
		case (op)
			lfa_pkg::OP_ADD_IMM, lfa_pkg::OP_ADD_REG: result = sum[7:0];
			lfa_pkg::OP_AND_IMM, lfa_pkg::OP_AND_REG: result = acc & operand;
			lfa_pkg::OP_BIT_CLR: result = fdata & ~mask;
			lfa_pkg::OP_BIT_SET: result = fdata | mask;
			default: result = fdata;
		endcase
		carry      = sum[8];
		half_carry = low_sum[4];
		zero       = (result == 8'h00);
	end
endmodule

/* File: hw/lfa_core.sv */
// apb-controlled execution datapath for literal, file and bit instructions
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module lfa_core #(
	parameter int INSTR_CLOCKS = lfa_pkg::INSTR_CLOCKS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// port pins
	input  wire logic [7:0]  port_pins,
	output logic [7:0]       port_latch,
	// instruction cycle marker
	output logic             tcy_tick
);
	////////////////////////////////////////////////////////////////////////
	// state
	lfa_pkg::state_t state;
	lfa_pkg::state_t next_state;
	logic [7:0]      acc;
	logic [7:0]      next_acc;
	logic [2:0]      flags;
	logic [2:0]      next_flags;
	logic [31:0]     cmd;
	logic [31:0]     next_cmd;
	logic [6:0]      faddr;
	logic [6:0]      next_faddr;
	logic            skip;
	logic            next_skip;
	logic            discard;
	logic            next_discard;
	logic [15:0]     div;
	logic [15:0]     next_div;
	logic [31:0]     rdata;
	logic [31:0]     next_rdata;
	logic            rd_ok;
	logic            next_rd_ok;

	// decoded command fields
	lfa_pkg::op_t    op;
	logic            dest;
	logic [2:0]      bsel;
	logic [6:0]      caddr;
	logic [7:0]      literal;

	// datapath wires
	logic [7:0]      alu_res;
	logic            alu_c;
	logic            alu_hc;
	logic            alu_z;
	logic            alu_bit;
	logic [6:0]      df_addr;
	logic            df_we;
	logic [7:0]      df_wdata;
	logic [7:0]      df_rdata;

	// bus decode
	logic            acc_phase;
	logic            busy;
	logic            stall;
	logic            hit_cmd;
	logic            hit_file;
	logic            mapped;
	logic            do_write;
	logic            do_read;
	logic            exec;
	logic            test_true;

	////////////////////////////////////////////////////////////////////////
	// field decode
	always_comb begin
		op      = lfa_pkg::op_t'(cmd[lfa_pkg::OP_LSB +: 4]);
		dest    = cmd[lfa_pkg::DEST_BIT];
		bsel    = cmd[lfa_pkg::BSEL_LSB +: 3];
		caddr   = cmd[lfa_pkg::ADDR_LSB +: 7];
		literal = cmd[lfa_pkg::LIT_LSB +: 8];
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode; commands and file accesses stall while an instruction runs
	always_comb begin
		acc_phase = psel && penable;
		busy      = (state != lfa_pkg::ST_IDLE);
		hit_cmd   = (paddr == lfa_pkg::CMD_OFS);
		hit_file  = (paddr == lfa_pkg::FILE_DATA_OFS);
		mapped    = (paddr == lfa_pkg::ACC_OFS) ||
			(paddr == lfa_pkg::STATUS_OFS) || hit_cmd ||
			(paddr == lfa_pkg::FILE_ADDR_OFS) || hit_file;
		stall     = busy && (hit_cmd || hit_file ||
			(paddr == lfa_pkg::ACC_OFS && pwrite) ||
			(paddr == lfa_pkg::STATUS_OFS && pwrite));
		// read words are captured a cycle early so prdata comes from a flop
		pready    = pwrite ? !stall : rd_ok;
		pslverr   = acc_phase && pready && !mapped;
		do_write  = acc_phase && pready && pwrite && mapped;
		do_read   = psel && !pwrite;
		prdata    = rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// instruction cycle divider; one tick every INSTR_CLOCKS, free running
	always_comb begin
		if (div == 16'(INSTR_CLOCKS - 1))
			next_div = 16'h0000;
		else
			next_div = div + 16'h0001;
		tcy_tick = (div == 16'(INSTR_CLOCKS - 1));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div <= 16'h0000;
		else
			div <= next_div;
	end

	////////////////////////////////////////////////////////////////////////
	// datapath
	lfa_alu_unit u_alu (
		.op         (op),
		.acc        (acc),
		.literal    (literal),
		.fdata      (df_rdata),
		.bsel       (bsel),
		.result     (alu_res),
		.carry      (alu_c),
		.half_carry (alu_hc),
		.zero       (alu_z),
		.bit_val    (alu_bit)
	);

	lfa_data_file #(
		.DEPTH (128)
	) u_file (
		.pclk       (pclk),
		.presetn    (presetn),
		.addr       (df_addr),
		.wr_en      (df_we),
		.wr_data    (df_wdata),
		.use_pins   (busy),
		.rd_data    (df_rdata),
		.port_pins  (port_pins),
		.port_latch (port_latch)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer and register file
	always_comb begin
		next_state   = state;
		next_acc     = acc;
		next_flags   = flags;
		next_cmd     = cmd;
		next_faddr   = faddr;
		next_skip    = skip;
		next_discard = discard;
		df_addr      = busy ? caddr : faddr;
		df_we        = 1'b0;
		df_wdata     = alu_res;
		exec         = (state == lfa_pkg::ST_WAIT) && tcy_tick && !discard;
		test_true    = ((op == lfa_pkg::OP_SKIP_SET) && alu_bit) ||
			((op == lfa_pkg::OP_SKIP_CLR) && !alu_bit);

		// bus writes; only reachable while idle for the stalled offsets
		if (do_write) begin
			case (paddr)
				lfa_pkg::ACC_OFS: next_acc = pwdata[7:0];
				lfa_pkg::STATUS_OFS: next_flags = pwdata[2:0];
				lfa_pkg::CMD_OFS: begin
					next_cmd     = pwdata;
					next_state   = lfa_pkg::ST_WAIT;
					next_discard = skip;
					next_skip    = 1'b0;
				end
				lfa_pkg::FILE_ADDR_OFS: next_faddr = pwdata[6:0];
				lfa_pkg::FILE_DATA_OFS: begin
					df_we    = 1'b1;
					df_wdata = pwdata[7:0];
				end
				default: ;
			endcase
		end

		case (state)
			lfa_pkg::ST_IDLE: ;
			lfa_pkg::ST_WAIT: begin
				if (tcy_tick) begin
					next_state   = lfa_pkg::ST_IDLE;
					next_discard = 1'b0;
					if (exec) begin
						case (op)
							lfa_pkg::OP_ADD_IMM, lfa_pkg::OP_ADD_REG: begin
								next_flags[lfa_pkg::CARRY_BIT] = alu_c;
								next_flags[lfa_pkg::HALF_BIT]  = alu_hc;
								next_flags[lfa_pkg::ZERO_BIT]  = alu_z;
							end
							lfa_pkg::OP_AND_IMM, lfa_pkg::OP_AND_REG:
								next_flags[lfa_pkg::ZERO_BIT] = alu_z;
							default: ;
						endcase
						case (op)
							lfa_pkg::OP_ADD_IMM, lfa_pkg::OP_AND_IMM:
								next_acc = alu_res;
							lfa_pkg::OP_ADD_REG, lfa_pkg::OP_AND_REG: begin
								if (dest)
									df_we = 1'b1;
								else
									next_acc = alu_res;
							end
							lfa_pkg::OP_BIT_CLR, lfa_pkg::OP_BIT_SET:
								df_we = 1'b1;
							lfa_pkg::OP_SKIP_SET, lfa_pkg::OP_SKIP_CLR: begin
								if (test_true) begin
									next_state = lfa_pkg::ST_NOP;
									next_skip  = 1'b1;
								end
							end
							default: ;
						endcase
					end
				end
			end
			lfa_pkg::ST_NOP: begin
				// second instruction cycle of a true test does nothing
				if (tcy_tick)
					next_state = lfa_pkg::ST_IDLE;
			end
			default: next_state = lfa_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= lfa_pkg::ST_IDLE;
			acc     <= lfa_pkg::ACC_RST;
			flags   <= lfa_pkg::FLAGS_RST;
			cmd     <= lfa_pkg::CMD_RST;
			faddr   <= lfa_pkg::FADDR_RST;
			skip    <= 1'b0;
			discard <= 1'b0;
		end else begin
			state   <= next_state;
			acc     <= next_acc;
			flags   <= next_flags;
			cmd     <= next_cmd;
			faddr   <= next_faddr;
			skip    <= next_skip;
			discard <= next_discard;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read capture; a word taken while stalled is never handed out
	always_comb begin
		next_rdata = rdata;
		next_rd_ok = do_read && !stall && !(acc_phase && pready);
		if (do_read) begin
			case (paddr)
				lfa_pkg::ACC_OFS: next_rdata = {24'h000000, acc};
				lfa_pkg::STATUS_OFS: next_rdata = {27'h0000000, skip, busy,
					flags};
				lfa_pkg::CMD_OFS: next_rdata = cmd;
				lfa_pkg::FILE_ADDR_OFS: next_rdata = {25'h0000000, faddr};
				lfa_pkg::FILE_DATA_OFS: next_rdata = {24'h000000, df_rdata};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= 32'h00000000;
			rd_ok <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rd_ok <= next_rd_ok;
		end
	end
endmodule

/* File: hw/lfa_data_file.sv */
// data register file with one port register whose pins read back while use_pins is set, its latch otherwise
`timescale 1ns/1ps
module lfa_data_file #(
	parameter int DEPTH = 128
) (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// access port
	input  wire logic [6:0] addr,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic       use_pins,
	output logic [7:0]      rd_data,
	// port pins
	input  wire logic [7:0] port_pins,
	output logic [7:0]      port_latch
);
	logic [7:0] mem [DEPTH];

	// the array has no reset; only the port latch must be defined
	always_ff @(posedge pclk) begin
		if (wr_en)
			mem[addr] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			port_latch <= 8'h00;
		else if (wr_en && addr == lfa_pkg::IO_PORT_ADDR)
			port_latch <= wr_data;
	end

	always_comb begin
		if (addr == lfa_pkg::IO_PORT_ADDR)
			rd_data = use_pins ? port_pins : port_latch;
		else
			rd_data = mem[addr];
	end
endmodule

/* File: hw/lfa_pkg.sv */
// constants, register map and encodings for the literal/file alu block
package lfa_pkg;

	// register byte offsets
	localparam logic [7:0] ACC_OFS       = 8'h00;
	localparam logic [7:0] STATUS_OFS    = 8'h04;
	localparam logic [7:0] CMD_OFS       = 8'h08;
	localparam logic [7:0] FILE_ADDR_OFS = 8'h0C;
	localparam logic [7:0] FILE_DATA_OFS = 8'h10;

	// status register bit positions
	localparam int CARRY_BIT = 0;
	localparam int HALF_BIT  = 1;
	localparam int ZERO_BIT  = 2;
	localparam int BUSY_BIT  = 3;
	localparam int SKIP_BIT  = 4;

	// command word field positions
	localparam int OP_LSB   = 0;
	localparam int DEST_BIT = 4;
	localparam int BSEL_LSB = 5;
	localparam int ADDR_LSB = 8;
	localparam int LIT_LSB  = 16;

	// reset values
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [2:0]  FLAGS_RST = 3'h0;
	localparam logic [31:0] CMD_RST   = 32'h00000000;
	localparam logic [6:0]  FADDR_RST = 7'h00;

	// pclk cycles per instruction cycle, and the address of the port register
	localparam int          INSTR_CLOCKS = 4;
	localparam logic [6:0]  IO_PORT_ADDR = 7'h06;

	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_ADD_IMM  = 4'h1,
		OP_AND_IMM  = 4'h2,
		OP_ADD_REG  = 4'h3,
		OP_AND_REG  = 4'h4,
		OP_BIT_CLR  = 4'h5,
		OP_BIT_SET  = 4'h6,
		OP_SKIP_SET = 4'h7,
		OP_SKIP_CLR = 4'h8
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_NOP  = 2'b10
	} state_t;

endpackage

/* File: tb/lfa_core_properties.sv */
// port assertions for the literal/file alu core
`timescale 1ns/1ps
module lfa_core_properties #(
	parameter int INSTR_CLOCKS = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  port_pins,
	input wire logic [7:0]  port_latch,
	input wire logic        tcy_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped, done, seen, next_seen;
	int   cnt, next_cnt;
	assign mapped = paddr inside {lfa_pkg::ACC_OFS, lfa_pkg::STATUS_OFS,
		lfa_pkg::CMD_OFS, lfa_pkg::FILE_ADDR_OFS, lfa_pkg::FILE_DATA_OFS};
	assign done = psel && penable && pready;
	// the divider phase is unknown until the first tick is seen
	always_comb begin
		next_seen = seen | tcy_tick;
		next_cnt = tcy_tick ? 0 : cnt + 1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 1'b0;
			cnt <= 0;
		end else begin
			seen <= next_seen;
			cnt <= next_cnt;
		end
	end
	sequence rd_done(logic [7:0] a);
		done && !pwrite && paddr == a;
	endsequence
	a_tick_period: assert property (
		seen |-> tcy_tick == (cnt == INSTR_CLOCKS - 1))
		else $error("instruction tick period wrong");
	a_err_unmapped: assert property (psel && penable && !mapped
		|-> pslverr && pready) else $error("unmapped access not refused");
	a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_stall_bound: assert property (psel && penable && !pready
		|-> ##[1:64] pready) else $error("stall too long");
	a_bad_read_zero: assert property (done && !pwrite && !mapped
		|-> prdata == 32'h00000000) else $error("unmapped read not zero");
	a_acc_read_width: assert property (rd_done(lfa_pkg::ACC_OFS)
		|-> prdata[31:8] == 24'h000000) else $error("acc upper bits");
	a_stat_read_width: assert property (rd_done(lfa_pkg::STATUS_OFS)
		|-> prdata[31:5] == 27'h0000000) else $error("status upper bits");
	a_addr_read_width: assert property (rd_done(lfa_pkg::FILE_ADDR_OFS)
		|-> prdata[31:7] == 25'h0000000) else $error("address upper bits");
	a_latch_cause: assert property ($changed(port_latch) |->
		$past(tcy_tick) || $past(done && pwrite
		&& paddr == lfa_pkg::FILE_DATA_OFS)) else $error("latch changed");
endmodule
bind lfa_core lfa_core_properties #(.INSTR_CLOCKS(INSTR_CLOCKS)) u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .port_pins, .port_latch, .tcy_tick);

/* File: tb/lfa_pin_source.sv */
// model of the outside circuit driving the port pins
`timescale 1ns/1ps
module lfa_pin_source (
	input wire logic       pclk,
	input wire logic [7:0] level,
	output logic [7:0]     port_pins
);
	// pins settle one clock after the bench picks a level
	always_ff @(posedge pclk) port_pins <= level;
endmodule

/* File: tb/test_lfa_core.sv */
// self-checking bench for the literal/file alu core
`timescale 1ns/1ps
module test_lfa_core;
	localparam int INSTR_CLK = 8;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, pins = 8'hA5;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic        pready, pslverr, tcy_tick, err;
	logic [7:0]  port_pins, port_latch, m_acc, mem [128];
	logic [2:0]  m_fl;
	logic        m_skip;
	int          err_count = 0, tests_run = 0, ticks = 0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) if (tcy_tick === 1'b1) ticks <= ticks + 1;
	lfa_pin_source peer (.pclk, .level(pins), .port_pins);
	lfa_core #(.INSTR_CLOCKS(INSTR_CLK)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.port_pins, .port_latch, .tcy_tick);
	////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 100) begin
			err_count++;
			stop_test();
		end
	endtask
	function automatic logic [10:0] add_f(logic [7:0] x, logic [7:0] y);
		logic [8:0] s;
		s = {1'b0, x} + {1'b0, y};
		return {s[7:0] == 8'h00, x[3:0] + y[3:0] > 5'h0F, s};
	endfunction
	task run(input lfa_pkg::op_t op, input logic d, input logic [2:0] b,
		input logic [6:0] a, input logic [7:0] k);
		logic [7:0] v;
		logic [10:0] r;
		logic dropped;
		int t0, n;
		apb(1'b1, lfa_pkg::CMD_OFS, {8'h00, k, 1'b0, a, b, d, op});
		t0 = ticks;
		n = 0;
		do begin
			apb(1'b0, lfa_pkg::STATUS_OFS, 32'h00000000);
			n++;
		end while (rd[3] !== 1'b0 && n < 50);
		if (rd[3] !== 1'b0) begin
			err_count++;
			stop_test();
		end
		v = (a == lfa_pkg::IO_PORT_ADDR) ? pins : mem[a];
		dropped = m_skip;
		m_skip = 1'b0;
		r = {m_fl, v};
		case (op)
		lfa_pkg::OP_ADD_IMM: r = add_f(m_acc, k);
		lfa_pkg::OP_ADD_REG: r = add_f(m_acc, v);
		lfa_pkg::OP_AND_IMM: r = {(m_acc & k) == 8'h00, m_fl[1:0], m_acc & k};
		lfa_pkg::OP_AND_REG: r = {(m_acc & v) == 8'h00, m_fl[1:0], m_acc & v};
		lfa_pkg::OP_BIT_CLR: r[7:0] = v & ~(8'h01 << b);
		lfa_pkg::OP_BIT_SET: r[7:0] = v | (8'h01 << b);
		lfa_pkg::OP_SKIP_SET: m_skip = !dropped && v[b];
		lfa_pkg::OP_SKIP_CLR: m_skip = !dropped && !v[b];
		default: ;
		endcase
		if (!dropped && op inside {[lfa_pkg::OP_ADD_IMM:lfa_pkg::OP_BIT_SET]})
			begin
			m_fl = r[10:8];
			if (op < lfa_pkg::OP_ADD_REG || (op < lfa_pkg::OP_BIT_CLR && !d))
				m_acc = r[7:0];
			else
				mem[a] = r[7:0];
		end
		if (!dropped && op > lfa_pkg::OP_BIT_SET)
			check(32'(ticks - t0), m_skip ? 32'h2 : 32'h1);
		check({27'h0, rd[4:0]}, {27'h0, m_skip, 1'b0, m_fl});
		apb(1'b0, lfa_pkg::ACC_OFS, 32'h00000000);
		check(rd, {24'h000000, m_acc});
		apb(1'b1, lfa_pkg::FILE_ADDR_OFS, {25'h0, a});
		apb(1'b0, lfa_pkg::FILE_DATA_OFS, 32'h00000000);
		check(rd, {24'h000000, mem[a]});
		check({24'h000000, port_latch}, {24'h000000, mem[6]});
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h1D87));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, lfa_pkg::ACC_OFS, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'b0, lfa_pkg::STATUS_OFS, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'b0, lfa_pkg::CMD_OFS, 32'h00000000);
		check(rd, lfa_pkg::CMD_RST);
		apb(1'b0, lfa_pkg::FILE_ADDR_OFS, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		check({31'h0, err}, 32'h00000001);
		apb(1'b0, 8'h14, 32'h00000000);
		check({31'h0, err}, 32'h00000001);
		check(rd, 32'h00000000);
		$display("reset and refusal test done");
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'($urandom);
			apb(1'b1, lfa_pkg::FILE_ADDR_OFS, 32'(i));
			apb(1'b1, lfa_pkg::FILE_DATA_OFS, {24'h000000, mem[i]});
		end
		m_fl = 3'h0;
		m_skip = 1'b0;
		// the acc write lands while the nop is busy, so it must stall
		apb(1'b1, lfa_pkg::CMD_OFS, 32'h00000000);
		apb(1'b1, lfa_pkg::ACC_OFS, 32'h000000FF);
		m_acc = 8'hFF;
		run(lfa_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01);
		run(lfa_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h0F);
		run(lfa_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01);
		run(lfa_pkg::OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'hEF);
		run(lfa_pkg::OP_BIT_SET, 1'b0, 3'h7, 7'h7F, 8'h00);
		run(lfa_pkg::OP_SKIP_SET, 1'b0, 3'h7, 7'h7F, 8'h00);
		run(lfa_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h55);
		run(lfa_pkg::OP_SKIP_CLR, 1'b0, 3'h7, 7'h7F, 8'h00);
		run(lfa_pkg::OP_BIT_CLR, 1'b0, 3'h7, 7'h7F, 8'h00);
		run(lfa_pkg::OP_SKIP_CLR, 1'b0, 3'h7, 7'h7F, 8'h00);
		run(lfa_pkg::OP_BIT_SET, 1'b0, 3'h0, 7'h7F, 8'h00);
		pins <= 8'h3C;
		run(lfa_pkg::OP_ADD_REG, 1'b1, 3'h0, 7'h06, 8'h00);
		$display("corner case test done");
		for (int i = 0; i < 80; i++) begin
			if (i % 8 == 0)
				pins <= 8'($urandom);
			run(lfa_pkg::op_t'(4'($urandom_range(8, 1))), 1'($urandom),
				3'($urandom), 7'($urandom), 8'($urandom));
		end
		$display("random test done");
		stop_test();
	end
endmodule
